// ==== core/rx_perf_pkg.sv ====
// Purpose: shared constants of the receive performance monitor
// Assumes: byte registers, each on one aligned APB word (byte address = 4 * index)
// Notes: indices below are the register numbers; the bus address is four times each
package rx_perf_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_ABORT_PKT0 = 10'h110;
  localparam logic [IDX_W-1:0] IDX_ABORT_PKT1 = 10'h111;
  localparam logic [IDX_W-1:0] IDX_ABORT_PKT2 = 10'h112;
  localparam logic [IDX_W-1:0] IDX_SIZE_PKT0 = 10'h114;
  localparam logic [IDX_W-1:0] IDX_SIZE_PKT1 = 10'h115;
  localparam logic [IDX_W-1:0] IDX_SIZE_PKT2 = 10'h116;
  localparam logic [IDX_W-1:0] IDX_GOOD_BYTE0 = 10'h118;
  localparam logic [IDX_W-1:0] IDX_GOOD_BYTE1 = 10'h119;
  localparam logic [IDX_W-1:0] IDX_GOOD_BYTE2 = 10'h11A;
  localparam logic [IDX_W-1:0] IDX_GOOD_BYTE3 = 10'h11B;
  localparam logic [IDX_W-1:0] IDX_ABORT_BYTE0 = 10'h11C;
  localparam logic [IDX_W-1:0] IDX_ABORT_BYTE1 = 10'h11D;
  localparam logic [IDX_W-1:0] IDX_ABORT_BYTE2 = 10'h11E;
  localparam logic [IDX_W-1:0] IDX_ABORT_BYTE3 = 10'h11F;
  localparam logic [IDX_W-1:0] IDX_UPDATE_REQ = 10'h120;
  localparam logic [IDX_W-1:0] IDX_UPDATE_DONE = 10'h121;
  localparam logic [IDX_W-1:0] IDX_HDR_STATUS = 10'h122;
  localparam logic [IDX_W-1:0] IDX_HDR_INT_EN = 10'h123;
  localparam logic [IDX_W-1:0] IDX_EXP_SAP_HIGH = 10'h130;
  localparam logic [IDX_W-1:0] IDX_EXP_SAP_LOW = 10'h131;
  localparam logic [IDX_W-1:0] IDX_EXP_CONTROL = 10'h132;
  localparam logic [IDX_W-1:0] IDX_EXP_ADDRESS = 10'h133;
  localparam logic [IDX_W-1:0] IDX_HDR_CLEAR = 10'h134;
  localparam int PKT_CNT_W = 24;
  localparam int BYTE_CNT_W = 32;
  localparam int NUM_HDR_FLAGS = 4;
  localparam int BIT_ADDRESS = 0;
  localparam int BIT_CONTROL = 1;
  localparam int BIT_SAP_LOW = 2;
  localparam int BIT_SAP_HIGH = 3;
  localparam int BIT_UPDATE = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_EXP_SAP_HIGH = 8'h00;
  localparam logic [7:0] RST_EXP_SAP_LOW = 8'h00;
  localparam logic [7:0] RST_EXP_CONTROL = 8'h00;
  localparam logic [7:0] RST_EXP_ADDRESS = 8'h00;
  localparam logic [NUM_HDR_FLAGS-1:0] RST_FLAGS = 4'h0;
  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_COPY = 2'b01,
    UPD_DONE = 2'b11
  } upd_state_t;
endpackage : rx_perf_pkg

// ==== core/rx_packet_perf_monitor.sv ====
// Purpose: receive packet performance counters with snapshot update and header checks
// Assumes: event inputs synchronous to ref_clk; one packet end per cycle at most
// Notes: APB slave, one wait state per access; byte registers in the low data bits
// Function
// R1: count packets that ended with an abort, 24 bits, three byte registers.
// R2: count packets too short, too long or not whole bytes, 24 bits.
// R3: bytes of aborted, size-bad or FCS-bad packets go to the aborted byte count.
// R4: count bytes of clean packets stored, 32 bits.
// R5: count bytes of aborted packets stored, 32 bits, separately.
// R6: bytes later discarded downstream may be counted too.
// R7: counters appear as ascending byte registers, lowest byte at lowest address.
// R8: request rising edge copies live counts to snapshots and resets the live counts.
// R9: the update touches only these receive counters.
// R10: done flag sets when update finishes, clears when request returns to 0.
// R11: flag bit 3 latches when received SAP high octet differs from expected.
// R12: flag bit 2 latches when received SAP low octet differs from expected.
// R13: flag bit 1 latches when received control field differs from expected.
// R14: flag bit 0 latches when received address field differs from expected.
// R15: flags stay set until status register is read; that read clears them. The code also clears them by a write of ones to the clear register.
// R16: each flag has an enable bit that lets it raise the interrupt.
// R17: a mismatch in the same cycle as the clearing read keeps its flag set.
//
// The implementer's own choice: the APB slave port.
`default_nettype none
`timescale 1ns/1ps
module rx_packet_perf_monitor
  import rx_perf_pkg::*;
#(
  parameter int LEN_W = 16
) (
  input wire logic ref_clk, // system clock, 25 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic pktEnd, // one-cycle pulse at the end of a stored packet
  input wire logic pktAbort, // packet carried an abort indication
  input wire logic pktSizeErr, // packet size violation
  input wire logic pktFcsErr, // packet had an FCS error
  input wire logic [LEN_W-1:0] pktLen, // bytes written to the receive fifo
  input wire logic hdrValid, // one-cycle pulse, header fields valid
  input wire logic [7:0] rxAddress, // received address field
  input wire logic [7:0] rxControl, // received control field
  input wire logic [7:0] rxSapLow, // received SAP low octet
  input wire logic [7:0] rxSapHigh, // received SAP high octet
  output logic irq // level interrupt, high while an enabled flag is set
);

  logic [PKT_CNT_W-1:0] abortPktLive_r;
  logic [PKT_CNT_W-1:0] sizePktLive_r;
  logic [BYTE_CNT_W-1:0] goodByteLive_r;
  logic [BYTE_CNT_W-1:0] abortByteLive_r;
  logic [PKT_CNT_W-1:0] abortPktSnap_r;
  logic [PKT_CNT_W-1:0] sizePktSnap_r;
  logic [BYTE_CNT_W-1:0] goodByteSnap_r;
  logic [BYTE_CNT_W-1:0] abortByteSnap_r;
  logic updateReq_r;
  logic updateDone_r;
  upd_state_t updState_r;
  upd_state_t updState_nxt;
  logic [7:0] expSapHigh_r;
  logic [7:0] expSapLow_r;
  logic [7:0] expControl_r;
  logic [7:0] expAddress_r;
  logic [NUM_HDR_FLAGS-1:0] hdrFlags_r;
  logic [NUM_HDR_FLAGS-1:0] hdrIntEn_r;
  logic [NUM_HDR_FLAGS-1:0] mismatch;
  logic [NUM_HDR_FLAGS-1:0] flagClr;
  logic [IDX_W-1:0] regIdx;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic [7:0] rdByte;
  logic rdHit;
  logic badPkt;
  logic [BYTE_CNT_W-1:0] lenExt;
  logic doCopy;

  assign regIdx = paddr[ADDR_W-1:2];
  // a request is taken at the edge that sees the wait state over
  assign access = psel & penable & pready;
  assign wrAccess = access & pwrite;
  assign rdAccess = access & ~pwrite;

  // apb answer: one wait state, data and error captured on the edge that raises ready
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
        pslverr <= ~rdHit;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // read decode; write-only clear register reads as zero
  always_comb
  begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (regIdx)
      IDX_ABORT_PKT0: rdByte = abortPktSnap_r[7:0]; // R7
      IDX_ABORT_PKT1: rdByte = abortPktSnap_r[15:8]; // R7
      IDX_ABORT_PKT2: rdByte = abortPktSnap_r[23:16]; // R7
      IDX_SIZE_PKT0: rdByte = sizePktSnap_r[7:0];
      IDX_SIZE_PKT1: rdByte = sizePktSnap_r[15:8];
      IDX_SIZE_PKT2: rdByte = sizePktSnap_r[23:16];
      IDX_GOOD_BYTE0: rdByte = goodByteSnap_r[7:0];
      IDX_GOOD_BYTE1: rdByte = goodByteSnap_r[15:8];
      IDX_GOOD_BYTE2: rdByte = goodByteSnap_r[23:16];
      IDX_GOOD_BYTE3: rdByte = goodByteSnap_r[31:24];
      IDX_ABORT_BYTE0: rdByte = abortByteSnap_r[7:0];
      IDX_ABORT_BYTE1: rdByte = abortByteSnap_r[15:8];
      IDX_ABORT_BYTE2: rdByte = abortByteSnap_r[23:16];
      IDX_ABORT_BYTE3: rdByte = abortByteSnap_r[31:24];
      IDX_UPDATE_REQ: rdByte = {7'h00, updateReq_r};
      IDX_UPDATE_DONE: rdByte = {7'h00, updateDone_r};
      IDX_HDR_STATUS: rdByte = {4'h0, hdrFlags_r};
      IDX_HDR_INT_EN: rdByte = {4'h0, hdrIntEn_r};
      IDX_EXP_SAP_HIGH: rdByte = expSapHigh_r;
      IDX_EXP_SAP_LOW: rdByte = expSapLow_r;
      IDX_EXP_CONTROL: rdByte = expControl_r;
      IDX_EXP_ADDRESS: rdByte = expAddress_r;
      IDX_HDR_CLEAR: rdByte = 8'h00;
      default: rdHit = 1'b0;
    endcase
  end

  // software-written configuration
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      updateReq_r <= 1'b0;
      hdrIntEn_r <= RST_FLAGS;
      expSapHigh_r <= RST_EXP_SAP_HIGH;
      expSapLow_r <= RST_EXP_SAP_LOW;
      expControl_r <= RST_EXP_CONTROL;
      expAddress_r <= RST_EXP_ADDRESS;
    end
    else if (wrAccess)
    begin
      case (regIdx)
        IDX_UPDATE_REQ: updateReq_r <= pwdata[BIT_UPDATE];
        IDX_HDR_INT_EN: hdrIntEn_r <= pwdata[NUM_HDR_FLAGS-1:0]; // R16
        IDX_EXP_SAP_HIGH: expSapHigh_r <= pwdata[7:0];
        IDX_EXP_SAP_LOW: expSapLow_r <= pwdata[7:0];
        IDX_EXP_CONTROL: expControl_r <= pwdata[7:0];
        IDX_EXP_ADDRESS: expAddress_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // update sequencer: copy once per rising request, then hold done
  always_comb
  begin
    updState_nxt = updState_r;
    case (updState_r)
      UPD_IDLE: if (updateReq_r) updState_nxt = UPD_COPY; // R8
      UPD_COPY: updState_nxt = UPD_DONE;
      UPD_DONE: if (!updateReq_r) updState_nxt = UPD_IDLE; // R10
      default: updState_nxt = UPD_IDLE;
    endcase
  end

  // a request dropped before the copy still completes the copy,
  // then passes through UPD_DONE to idle one cycle later, so done is never left stale
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      updState_r <= UPD_IDLE;
    else
      updState_r <= updState_nxt;
  end

  assign doCopy = (updState_r == UPD_COPY);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      updateDone_r <= 1'b0;
    else if (!updateReq_r)
      updateDone_r <= 1'b0; // R10
    else if (doCopy)
      updateDone_r <= 1'b1; // R10
  end

  assign badPkt = pktAbort | pktSizeErr | pktFcsErr;
  assign lenExt = {{(BYTE_CNT_W-LEN_W){1'b0}}, pktLen};

  // live counters; a packet ending in the copy cycle lands in the new interval
  // so no event is lost across an update. discarded bytes are counted. R6
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      abortPktLive_r <= '0;
      sizePktLive_r <= '0;
      goodByteLive_r <= '0;
      abortByteLive_r <= '0;
    end
    else if (doCopy)
    begin
      abortPktLive_r <= PKT_CNT_W'(pktEnd & pktAbort); // R8
      sizePktLive_r <= PKT_CNT_W'(pktEnd & pktSizeErr); // R8
      goodByteLive_r <= (pktEnd & ~badPkt) ? lenExt : '0; // R8
      abortByteLive_r <= (pktEnd & badPkt) ? lenExt : '0; // R8
    end
    else if (pktEnd)
    begin
      if (pktAbort)
        abortPktLive_r <= abortPktLive_r + PKT_CNT_W'(1); // R1
      if (pktSizeErr)
        sizePktLive_r <= sizePktLive_r + PKT_CNT_W'(1); // R2
      if (badPkt)
        abortByteLive_r <= abortByteLive_r + lenExt; // R3 R5
      else
        goodByteLive_r <= goodByteLive_r + lenExt; // R4
    end
  end

  // snapshots seen by software; only these receive counters are touched. R9
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      abortPktSnap_r <= '0;
      sizePktSnap_r <= '0;
      goodByteSnap_r <= '0;
      abortByteSnap_r <= '0;
    end
    else if (doCopy)
    begin
      abortPktSnap_r <= abortPktLive_r; // R8
      sizePktSnap_r <= sizePktLive_r; // R8
      goodByteSnap_r <= goodByteLive_r; // R8
      abortByteSnap_r <= abortByteLive_r; // R8
    end
  end

  // header comparison against the expected values
  always_comb
  begin
    mismatch = '0;
    if (hdrValid)
    begin
      mismatch[BIT_SAP_HIGH] = (rxSapHigh != expSapHigh_r); // R11
      mismatch[BIT_SAP_LOW] = (rxSapLow != expSapLow_r); // R12
      mismatch[BIT_CONTROL] = (rxControl != expControl_r); // R13
      mismatch[BIT_ADDRESS] = (rxAddress != expAddress_r); // R14
    end
  end

  // cleared by reading the status word or by the write-one clear register
  always_comb
  begin
    flagClr = '0;
    // clear only what the read returned: a flag set in the wait state was not reported yet
    if (rdAccess && regIdx == IDX_HDR_STATUS)
      flagClr = prdata[NUM_HDR_FLAGS-1:0]; // R15
    else if (wrAccess && regIdx == IDX_HDR_CLEAR)
      flagClr = pwdata[NUM_HDR_FLAGS-1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_HDR_FLAGS; gi++)
    begin : g_flag
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          hdrFlags_r[gi] <= 1'b0;
        else if (mismatch[gi])
          hdrFlags_r[gi] <= 1'b1; // R17
        else if (flagClr[gi])
          hdrFlags_r[gi] <= 1'b0; // R15
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(hdrFlags_r & hdrIntEn_r); // R16
  end

endmodule : rx_packet_perf_monitor
`default_nettype wire

// ==== verif/rx_perf_asserts.sv ====
// Purpose: port checks of the receive monitor
// Assumes: two-cycle APB access phase
// Notes: bound at the foot
`default_nettype none
`timescale 1ns/1ps
module rx_perf_asserts
  import rx_perf_pkg::*;
#(
  parameter int LEN_W = 16
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic pktEnd, // packet end
  input wire logic pktAbort, // abort
  input wire logic pktSizeErr, // size bad
  input wire logic pktFcsErr, // fcs bad
  input wire logic [LEN_W-1:0] pktLen, // length
  input wire logic hdrValid, // header
  input wire logic [7:0] rxAddress, // address
  input wire logic [7:0] rxControl, // control
  input wire logic [7:0] rxSapLow, // sap low
  input wire logic [7:0] rxSapHigh, // sap high
  input wire logic irq // interrupt
);
  logic [IDX_W-1:0] idx;
  logic rd;
  assign idx = paddr[11:2];
  assign rd = pready && psel && penable && !pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_READY_TIMING: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RD_BYTE: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (pready && idx == 10'h3FF |-> pslverr)
    else $error("unmapped not refused");
  AST_MAPPED: assert property (pready && idx >= IDX_ABORT_BYTE0 && idx <= IDX_HDR_STATUS |-> !pslverr)
    else $error("mapped refused");
  AST_DONE_BIT: assert property (rd && idx == IDX_UPDATE_DONE |-> prdata[31:1] == 31'h0)
    else $error("done reg bad");
  AST_STATUS_BITS: assert property (rd && idx == IDX_HDR_STATUS |-> prdata[31:4] == 28'h0)
    else $error("status reg bad");
  AST_IRQ_RISE: assert property ($rose(irq) |->
    $past(hdrValid, 2) || $past(hdrValid, 3) || $past(pready, 2) || $past(pready, 3))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |->
    $past(pready, 1) || $past(pready, 2) || $past(pready, 3))
    else $error("irq fell without access");
endmodule : rx_perf_asserts
bind rx_packet_perf_monitor rx_perf_asserts #(.LEN_W(LEN_W)) rx_perf_asserts_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pktEnd(pktEnd), .pktAbort(pktAbort), .pktSizeErr(pktSizeErr), .pktFcsErr(pktFcsErr),
  .pktLen(pktLen), .hdrValid(hdrValid), .rxAddress(rxAddress), .rxControl(rxControl),
  .rxSapLow(rxSapLow), .rxSapHigh(rxSapHigh), .irq(irq));
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the receive monitor
// Assumes: read results checked by a queue monitor
// Notes: random packets from an xorshift source
`default_nettype none
`timescale 1ns/1ps
module tb_top
  import rx_perf_pkg::*;
;
  logic ref_clk, rst, psel, penable, pwrite, pktEnd, pktAbort, pktSizeErr, pktFcsErr, hdrValid;
  logic pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, seed, goodB, abB, sG, sA, e;
  logic [15:0] pktLen;
  logic [7:0] rxAddress, rxControl, rxSapLow, rxSapHigh;
  logic [23:0] abPkt, szPkt, sAP, sSP;
  logic [32:0] expQ[$];
  int fails, num_checks;
  rx_packet_perf_monitor rx_packet_perf_monitor_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pktEnd(pktEnd), .pktAbort(pktAbort),
    .pktSizeErr(pktSizeErr), .pktFcsErr(pktFcsErr), .pktLen(pktLen), .hdrValid(hdrValid),
    .rxAddress(rxAddress), .rxControl(rxControl), .rxSapLow(rxSapLow),
    .rxSapHigh(rxSapHigh), .irq(irq));
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(input logic [32:0] g, input logic [32:0] x);
    num_checks++;
    if (g !== x)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp
  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // reads note their expectation; the monitor below compares at completion
  task automatic apb(input logic w, input int i, input logic [7:0] d, input logic [32:0] x);
    int n;
    if (!w)
      expQ.push_back(x);
    psel <= 1;
    pwrite <= w;
    paddr <= {i[9:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      results();
    end
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : apb
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      if (expQ.size() > 0)
        cmp({pslverr, prdata}, expQ.pop_front());
      else
        fails++;
  task automatic pkt(input logic [31:0] r);
    pktEnd <= 1;
    {pktAbort, pktSizeErr, pktFcsErr} <= r[18:16];
    pktLen <= r[15:0];
    abPkt += r[18];
    szPkt += r[17];
    if (r[18:16] != 0) abB += r[15:0];
    else goodB += r[15:0];
    @(posedge ref_clk);
  endtask : pkt
  task automatic update();
    apb(1, IDX_UPDATE_REQ, 8'h01, 0);
    {sAP, sSP, sG, sA} = {abPkt, szPkt, goodB, abB};
    {abPkt, szPkt, goodB, abB} = 0;
    apb(0, IDX_UPDATE_DONE, 0, 33'h1);
    apb(1, IDX_UPDATE_REQ, 0, 0);
    apb(0, IDX_UPDATE_DONE, 0, 33'h0);
  endtask : update
  task automatic chkAll();
    for (int k = 0; k < 4; k++)
    begin
      if (k < 3) apb(0, IDX_ABORT_PKT0 + k, 0, {25'h0, sAP[8*k +: 8]});
      if (k < 3) apb(0, IDX_SIZE_PKT0 + k, 0, {25'h0, sSP[8*k +: 8]});
      apb(0, IDX_GOOD_BYTE0 + k, 0, {25'h0, sG[8*k +: 8]});
      apb(0, IDX_ABORT_BYTE0 + k, 0, {25'h0, sA[8*k +: 8]});
    end
  endtask : chkAll
  task automatic hdr(input logic [31:0] v);
    hdrValid <= 1;
    {rxSapHigh, rxSapLow, rxControl, rxAddress} <= v;
    @(posedge ref_clk);
    hdrValid <= 0;
    @(posedge ref_clk);
  endtask : hdr
  initial
  begin
    {rst, psel, penable, pwrite, pktEnd, pktAbort, pktSizeErr, pktFcsErr, hdrValid} = 9'h100;
    {paddr, pwdata, pktLen, rxAddress, rxControl, rxSapLow, rxSapHigh} = 0;
    {abPkt, szPkt, goodB, abB, sAP, sSP, sG, sA} = 0;
    seed = 58187;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    chkAll();
    apb(0, IDX_UPDATE_REQ, 0, 33'h0);
    apb(0, 10'h3FF, 0, {1'b1, 32'h0});
    apb(1, 10'h3FF, 8'hFF, 0);
    apb(1, IDX_GOOD_BYTE0, 8'hFF, 0);
    apb(0, IDX_GOOD_BYTE0, 0, 33'h0);
    repeat (40) pkt(rnd());
    pktEnd <= 0;
    update();
    chkAll();
    repeat (5) pkt(rnd());
    pktEnd <= 0;
    chkAll();
    update();
    chkAll();
    update();
    chkAll();
    e = rnd();
    for (int b = 0; b < 4; b++) apb(1, IDX_EXP_ADDRESS - b, e[8*b +: 8], 0);
    hdr(e);
    apb(0, IDX_HDR_STATUS, 0, 33'h0);
    apb(1, IDX_HDR_INT_EN, 8'h0F, 0);
    for (int b = 0; b < 4; b++)
    begin
      hdr(e ^ (32'h1 << 8*b));
      repeat (2) @(posedge ref_clk);
      cmp({32'h0, irq}, 33'h1);
      apb(0, IDX_HDR_STATUS, 0, 33'h1 << b);
      @(posedge ref_clk);
      cmp({32'h0, irq}, 33'h0);
      apb(0, IDX_HDR_STATUS, 0, 33'h0);
    end
    apb(1, IDX_HDR_INT_EN, 8'h0E, 0);
    apb(0, IDX_HDR_INT_EN, 0, 33'h0E);
    hdr(e ^ 32'h1);
    repeat (2) @(posedge ref_clk);
    cmp({32'h0, irq}, 33'h0);
    apb(1, IDX_HDR_CLEAR, 8'h01, 0);
    apb(0, IDX_HDR_STATUS, 0, 33'h0);
    hdr(e ^ 32'h1);
    // second mismatch lands on the clearing edge of the read
    fork
      apb(0, IDX_HDR_STATUS, 0, 33'h1);
      begin
        repeat (2) @(posedge ref_clk);
        hdr(e ^ 32'h100);
      end
    join
    apb(0, IDX_HDR_STATUS, 0, 33'h2);
    // a mismatch in the wait state is not in the returned byte and must survive the read
    fork
      apb(0, IDX_HDR_STATUS, 0, 33'h0);
      begin
        @(posedge ref_clk);
        hdr(e ^ 32'h1_0000);
      end
    join
    apb(0, IDX_HDR_STATUS, 0, 33'h4);
    update();
    for (int b = 0; b < 4; b++) apb(0, IDX_EXP_ADDRESS - b, 0, {25'h0, e[8*b +: 8]});
    cmp(33'(expQ.size()), 33'h0);
    results();
  end
endmodule : tb_top
`default_nettype wire
